/* File: rtl/bldc_cfg_pkg.sv */
// Constants for the motor output configuration block.
// Assumes an 8-bit register port with a 4-bit address.
package bldc_cfg_pkg;
  // Register offsets
  localparam logic [3:0] OFF_CONTROL_A  = 4'h0;
  localparam logic [3:0] OFF_CONTROL_B  = 4'h1;
  localparam logic [3:0] OFF_PHASE      = 4'h2;
  localparam logic [3:0] OFF_PARITY     = 4'h3;
  localparam logic [3:0] OFF_POLARITY   = 4'h4;
  localparam logic [3:0] OFF_COMPARE    = 4'h5;
  localparam logic [3:0] OFF_WEIGHT     = 4'h6;
  localparam logic [3:0] OFF_STATUS     = 4'h7;
  // Field positions
  localparam int CA_OE      = 7;
  localparam int CA_RST     = 6;
  localparam int CA_SENSOR  = 5;
  localparam int CA_DIRECT  = 4;
  localparam int CA_CURRENT = 3;
  localparam int CA_AUTO    = 2;
  localparam int CA_FILTER  = 1;
  localparam int CA_CAPSRC  = 0;
  localparam int CB_ZCEDGE  = 5;
  localparam int CB_HWDM    = 4;
  localparam int CB_SWDM    = 3;
  localparam int CB_OS2     = 2;
  localparam int PA_SAME    = 7;
  localparam int PA_READ    = 6;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // Multiplier scale shift (divide by 32)
  localparam int DIV_SHIFT = 5;
  // Threshold references in millivolts
  localparam logic [11:0] VREF_0 = 12'h0C8;
  localparam logic [11:0] VREF_1 = 12'h258;
  localparam logic [11:0] VREF_2 = 12'h4B0;
  localparam logic [11:0] VREF_3 = 12'h9C4;
  // Off times in ns and clock
  localparam int CLK_NS      = 20;
  localparam int OFF_T0_NS   = 5000;
  localparam int OFF_T1_NS   = 10000;
  localparam int OFF_T2_NS   = 15000;
  localparam int OFF_T3_NS   = 30000;
  localparam int OFF_SENS_NS = 1250;
  localparam logic [10:0] OFF_T0_CYC   = 11'((OFF_T0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] OFF_T1_CYC   = 11'((OFF_T1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] OFF_T2_CYC   = 11'((OFF_T2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] OFF_T3_CYC   = 11'((OFF_T3_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] OFF_SENS_CYC = 11'((OFF_SENS_NS + CLK_NS - 1) / CLK_NS);
endpackage

/* File: rtl/bldc_output_config.sv */
// Configuration, preload and output channel logic of a motor bridge.
// Assumes event detection and capture registers live outside.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module bldc_output_config (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_commutation_evt,
  input  wire logic        i_zc_evt,
  input  wire logic [7:0]  i_prev_zc_capture,
  input  wire logic [7:0]  i_curr_zc_capture,
  input  wire logic        i_current_cmp,
  input  wire logic        i_phase_input_a,
  input  wire logic        i_phase_input_b,
  input  wire logic        i_phase_input_c,
  output logic      [5:0]  o_motor_channel_out,
  output logic      [5:0]  o_motor_channel_oe,
  output logic             o_step_timer_clk_en,
  output logic             o_periph_clk_en,
  output logic             o_regs_reset_req,
  output logic             o_sensor_mode,
  output logic             o_current_mode,
  output logic             o_auto_commutation,
  output logic             o_current_cmp_filtered,
  output logic      [7:0]  o_next_commutation_compare,
  output logic      [7:0]  o_commutation_delay,
  output logic      [1:0]  o_threshold_sel,
  output logic      [11:0] o_threshold_mv,
  output logic             o_zc_edge_sel,
  output logic             o_hw_demag_en,
  output logic             o_sw_demag_en,
  output logic             o_pwm_before_d_sel,
  output logic      [1:0]  o_pwm_after_d_sel,
  output logic      [1:0]  o_comparator_input_sel,
  output logic             o_comparator_phase,
  output logic             o_zc_demag_same_edge,
  output logic             o_bemf_read_parity,
  output logic      [5:0]  o_channel_parity,
  output logic      [10:0] o_off_time_cycles
);

  logic [7:0]  control_a_reg;
  logic [7:0]  control_b_reg;
  logic [3:0]  control_b_shadow_reg;
  logic [3:0]  control_b_shadow_next;
  logic [7:0]  phase_state_reg;
  logic [7:0]  phase_shadow_reg;
  logic [7:0]  phase_shadow_next;
  logic [7:0]  parity_config_reg;
  logic [5:0]  parity_shadow_reg;
  logic [5:0]  parity_shadow_next;
  logic [7:0]  polarity_config_reg;
  logic [7:0]  compare_reg;
  logic [7:0]  delay_weight_reg;
  logic [15:0] product;
  logic [7:0]  delay_next;
  logic        direct;
  logic        phase_wr;
  logic        commit;
  logic        filt_reg;

  assign direct   = control_a_reg[bldc_cfg_pkg::CA_DIRECT];
  assign phase_wr = i_wr && (i_addr == bldc_cfg_pkg::OFF_PHASE);
  // Commit source: commutation, or phase write under direct access
  assign commit = direct ? phase_wr : i_commutation_evt;

  // Shadow values after this cycle's write, so a coincident write commits too
  always_comb begin
    control_b_shadow_next = control_b_shadow_reg;
    phase_shadow_next     = phase_shadow_reg;
    parity_shadow_next    = parity_shadow_reg;
    if (i_wr && (i_addr == bldc_cfg_pkg::OFF_CONTROL_B)) begin
      control_b_shadow_next = i_wdata[5:2];
    end
    if (phase_wr) begin
      phase_shadow_next = i_wdata;
    end
    if (i_wr && (i_addr == bldc_cfg_pkg::OFF_PARITY)) begin
      parity_shadow_next = i_wdata[5:0];
    end
  end

  // Shadow copies
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_b_shadow_reg <= 4'h0;
      phase_shadow_reg     <= bldc_cfg_pkg::RST_REG;
      parity_shadow_reg    <= 6'h00;
    end else begin
      control_b_shadow_reg <= control_b_shadow_next;
      phase_shadow_reg     <= phase_shadow_next;
      parity_shadow_reg    <= parity_shadow_next;
    end
  end

  // Plain control register A
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_a_reg <= bldc_cfg_pkg::RST_REG;
    end else if (i_wr && (i_addr == bldc_cfg_pkg::OFF_CONTROL_A)) begin
      control_a_reg <= i_wdata;
    end
  end

  // Control register B: direct bits plus preloaded bits 5:2
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_b_reg <= bldc_cfg_pkg::RST_REG;
    end else begin
      if (i_wr && (i_addr == bldc_cfg_pkg::OFF_CONTROL_B)) begin
        control_b_reg[7:6] <= i_wdata[7:6];
        control_b_reg[1:0] <= i_wdata[1:0];
      end
      if (commit) begin
        control_b_reg[5:2] <= control_b_shadow_next;
      end
    end
  end

  // Active phase state, committed from shadow
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_state_reg <= bldc_cfg_pkg::RST_REG;
    end else if (commit) begin
      phase_state_reg <= phase_shadow_next;
    end
  end

  // Parity register: bits 7:6 direct, channel parity preloaded
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      parity_config_reg <= bldc_cfg_pkg::RST_REG;
    end else begin
      if (i_wr && (i_addr == bldc_cfg_pkg::OFF_PARITY)) begin
        parity_config_reg[7:6] <= i_wdata[7:6];
      end
      if (commit) begin
        parity_config_reg[5:0] <= parity_shadow_next;
      end
    end
  end

  // Polarity and off time
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      polarity_config_reg <= bldc_cfg_pkg::RST_REG;
    end else if (i_wr && (i_addr == bldc_cfg_pkg::OFF_POLARITY)) begin
      polarity_config_reg <= i_wdata;
    end
  end

  // Delay weight
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      delay_weight_reg <= bldc_cfg_pkg::RST_REG;
    end else if (i_wr && (i_addr == bldc_cfg_pkg::OFF_WEIGHT)) begin
      delay_weight_reg <= i_wdata;
    end
  end

  // Weight times selected capture, divided by 32
  assign product = {8'h00, delay_weight_reg} * {8'h00, (control_a_reg[bldc_cfg_pkg::CA_CAPSRC] ?
                   i_curr_zc_capture : i_prev_zc_capture)};
  assign delay_next = product[bldc_cfg_pkg::DIV_SHIFT +: 8];

  // Compare: software writes in switched mode, hardware loads in auto mode
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      compare_reg <= bldc_cfg_pkg::RST_REG;
    end else if (control_a_reg[bldc_cfg_pkg::CA_AUTO]) begin
      if (i_zc_evt) begin
        compare_reg <= delay_next;
      end
    end else if (i_wr && (i_addr == bldc_cfg_pkg::OFF_COMPARE)) begin
      compare_reg <= i_wdata;
    end
  end

  // Registered delay output
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_commutation_delay <= 8'h00;
    end else begin
      o_commutation_delay <= delay_next;
    end
  end

  // Current comparator filter: two equal samples needed
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      filt_reg               <= 1'b0;
      o_current_cmp_filtered <= 1'b0;
    end else begin
      filt_reg <= i_current_cmp;
      if (!control_a_reg[bldc_cfg_pkg::CA_FILTER]) begin
        o_current_cmp_filtered <= i_current_cmp;
      end else if (filt_reg == i_current_cmp) begin
        o_current_cmp_filtered <= i_current_cmp;
      end
    end
  end

  // Channel pins and enables
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_motor_channel_out <= 6'h00;
      o_motor_channel_oe  <= 6'h00;
    end else begin
      o_motor_channel_out <= ~(polarity_config_reg[5:0] ^ phase_state_reg[5:0]);
      o_motor_channel_oe  <= {6{control_a_reg[bldc_cfg_pkg::CA_OE]}};
    end
  end

  // Comparator phase selection
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_comparator_phase <= 1'b0;
    end else begin
      case (phase_state_reg[7:6])
        2'h0:    o_comparator_phase <= i_phase_input_a;
        2'h1:    o_comparator_phase <= i_phase_input_b;
        2'h2:    o_comparator_phase <= i_phase_input_c;
        default: o_comparator_phase <= 1'b0;
      endcase
    end
  end

  // Threshold and off time lookups
  always_comb begin
    case (control_b_reg[7:6])
      2'h0:    o_threshold_mv = bldc_cfg_pkg::VREF_0;
      2'h1:    o_threshold_mv = bldc_cfg_pkg::VREF_1;
      2'h2:    o_threshold_mv = bldc_cfg_pkg::VREF_2;
      default: o_threshold_mv = bldc_cfg_pkg::VREF_3;
    endcase
    if (control_a_reg[bldc_cfg_pkg::CA_SENSOR]) begin
      o_off_time_cycles = bldc_cfg_pkg::OFF_SENS_CYC;
    end else begin
      case (polarity_config_reg[7:6])
        2'h0:    o_off_time_cycles = bldc_cfg_pkg::OFF_T0_CYC;
        2'h1:    o_off_time_cycles = bldc_cfg_pkg::OFF_T1_CYC;
        2'h2:    o_off_time_cycles = bldc_cfg_pkg::OFF_T2_CYC;
        default: o_off_time_cycles = bldc_cfg_pkg::OFF_T3_CYC;
      endcase
    end
  end

  // Mode and field outputs
  assign o_periph_clk_en    = control_a_reg[bldc_cfg_pkg::CA_OE];
  assign o_step_timer_clk_en = control_a_reg[bldc_cfg_pkg::CA_OE] && !direct;
  assign o_regs_reset_req   = control_a_reg[bldc_cfg_pkg::CA_RST];
  assign o_sensor_mode      = control_a_reg[bldc_cfg_pkg::CA_SENSOR];
  assign o_current_mode     = control_a_reg[bldc_cfg_pkg::CA_CURRENT];
  assign o_auto_commutation = control_a_reg[bldc_cfg_pkg::CA_AUTO];
  assign o_next_commutation_compare = compare_reg;
  assign o_threshold_sel    = control_b_reg[7:6];
  assign o_zc_edge_sel      = control_b_reg[bldc_cfg_pkg::CB_ZCEDGE];
  assign o_hw_demag_en      = control_b_reg[bldc_cfg_pkg::CB_HWDM];
  assign o_sw_demag_en      = control_b_reg[bldc_cfg_pkg::CB_SWDM];
  assign o_pwm_before_d_sel = control_b_reg[bldc_cfg_pkg::CB_OS2] && !o_sensor_mode;
  assign o_pwm_after_d_sel  = control_b_reg[1:0];
  assign o_comparator_input_sel = phase_state_reg[7:6];
  assign o_zc_demag_same_edge = parity_config_reg[bldc_cfg_pkg::PA_SAME];
  assign o_bemf_read_parity = parity_config_reg[bldc_cfg_pkg::PA_READ];
  assign o_channel_parity   = parity_config_reg[5:0];

  // Read data one cycle after the strobe; active values only
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (i_addr == bldc_cfg_pkg::OFF_CONTROL_A) begin
      o_rdata <= control_a_reg;
    end else if (i_addr == bldc_cfg_pkg::OFF_CONTROL_B) begin
      o_rdata <= control_b_reg;
    end else if (i_addr == bldc_cfg_pkg::OFF_PHASE) begin
      o_rdata <= phase_state_reg;
    end else if (i_addr == bldc_cfg_pkg::OFF_PARITY) begin
      o_rdata <= parity_config_reg;
    end else if (i_addr == bldc_cfg_pkg::OFF_POLARITY) begin
      o_rdata <= polarity_config_reg;
    end else if (i_addr == bldc_cfg_pkg::OFF_COMPARE) begin
      o_rdata <= compare_reg;
    end else if (i_addr == bldc_cfg_pkg::OFF_WEIGHT) begin
      o_rdata <= delay_weight_reg;
    end else if (i_addr == bldc_cfg_pkg::OFF_STATUS) begin
      o_rdata <= {o_motor_channel_oe[0], direct, o_motor_channel_out};
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

/* File: test/bldc_output_config_assertions.sv */
// Port checker for the motor output configuration block.
// Assumes one clock; mirrors register writes to predict the pins.
`timescale 1ns/100ps
module bldc_output_config_assertions (
  input wire logic        i_sys_clk,
  input wire logic        i_arst_n,
  input wire logic [3:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_commutation_evt,
  input wire logic [5:0]  o_motor_channel_out,
  input wire logic [5:0]  o_motor_channel_oe,
  input wire logic        o_step_timer_clk_en,
  input wire logic        o_periph_clk_en,
  input wire logic        o_current_mode,
  input wire logic        o_sensor_mode,
  input wire logic        o_pwm_before_d_sel,
  input wire logic [10:0] o_off_time_cycles
);
  logic [1:0] rdy_reg;
  logic [7:0] wd_reg;
  logic [7:0] sh_reg;
  logic [7:0] act_reg;
  logic [5:0] pol_reg;
  logic       oe_reg;
  logic       dir_reg;
  logic       commit;
  logic       ph_wr;
  logic       ca_wr;
  logic [5:0] exp_pin;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Commit source and predicted pin levels
  assign ph_wr   = i_wr && i_addr == bldc_cfg_pkg::OFF_PHASE;
  assign ca_wr   = i_wr && i_addr == bldc_cfg_pkg::OFF_CONTROL_A;
  assign commit  = dir_reg ? ph_wr : i_commutation_evt;
  assign exp_pin = ~(pol_reg ^ act_reg[5:0]);
  // Mirror of written and committed state
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdy_reg <= 2'h0;
      wd_reg  <= 8'h00;
      sh_reg  <= 8'h00;
      act_reg <= 8'h00;
      pol_reg <= 6'h00;
      oe_reg  <= 1'b0;
      dir_reg <= 1'b0;
    end else begin
      if (rdy_reg != 2'h3) rdy_reg <= rdy_reg + 2'h1;
      wd_reg <= i_wdata;
      if (ph_wr) sh_reg <= i_wdata;
      if (commit) act_reg <= ph_wr ? i_wdata : sh_reg;
      if (ca_wr) oe_reg <= i_wdata[7];
      if (ca_wr) dir_reg <= i_wdata[4];
      if (i_wr && i_addr == bldc_cfg_pkg::OFF_POLARITY) pol_reg <= i_wdata[5:0];
    end
  end
  sequence s_dir_write;
    dir_reg && ph_wr;
  endsequence
  sequence s_pin_lands;
    ##2 o_motor_channel_out == $past(exp_pin);
  endsequence
  pin_model_a:
    assert property (rdy_reg == 2'h3 |=> o_motor_channel_out == $past(exp_pin)) else $error("pin level mismatch");
  direct_write_a:
    assert property (s_dir_write |-> s_pin_lands) else $error("direct phase write did not reach pins");
  preload_hold_a:
    assert property (rdy_reg == 2'h3 && !commit && !(i_wr && i_addr == bldc_cfg_pkg::OFF_POLARITY)
      |=> ##1 $stable(o_motor_channel_out)) else $error("pins moved without commit");
  oe_all_a:
    assert property (o_motor_channel_oe == {6{$past(o_periph_clk_en)}}) else $error("output enable mismatch");
  timer_clk_a:
    assert property (o_step_timer_clk_en == (oe_reg && !dir_reg)) else $error("timer clock enable wrong");
  current_mode_a:
    assert property (ca_wr |=> o_current_mode == wd_reg[3]) else $error("current mode not taken");
  phase_read_a:
    assert property (i_rd && i_addr == bldc_cfg_pkg::OFF_PHASE |=> o_rdata == $past(act_reg)) else $error("phase read");
  sensor_pwm_a:
    assert property (o_sensor_mode |-> !o_pwm_before_d_sel) else $error("before-D select in sensor mode");
  sensor_off_a:
    assert property (o_sensor_mode |-> o_off_time_cycles == 11'h03F) else $error("sensor off time wrong");
endmodule
bind bldc_output_config bldc_output_config_assertions chk (.i_sys_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_commutation_evt, .o_motor_channel_out, .o_motor_channel_oe, .o_step_timer_clk_en, .o_periph_clk_en,
  .o_current_mode, .o_sensor_mode, .o_pwm_before_d_sel, .o_off_time_cycles);

/* File: test/bridge_switch_model.sv */
// Gate inputs of the six bridge switches.
// Assumes pull-downs on the gate driver inputs.
`timescale 1ns/100ps
module bridge_switch_model (
  input  wire logic [5:0] i_pin,
  input  wire logic [5:0] i_oe,
  output logic      [5:0] o_gate
);
  // Released pins fall to the pull-down level
  assign o_gate = i_pin & i_oe;
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the motor output configuration block.
// Assumes the register offsets of the block's package.
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] r;} row_type;
  logic        i_sys_clk, i_arst_n, i_wr, i_rd, i_commutation_evt, i_zc_evt, i_current_cmp;
  logic        i_phase_input_a, i_phase_input_b, i_phase_input_c, o_regs_reset_req, o_auto_commutation;
  logic        o_step_timer_clk_en, o_periph_clk_en, o_sensor_mode, o_current_mode, o_current_cmp_filtered;
  logic        o_zc_edge_sel, o_hw_demag_en, o_sw_demag_en, o_pwm_before_d_sel, o_comparator_phase;
  logic        o_zc_demag_same_edge, o_bemf_read_parity;
  logic [1:0]  o_threshold_sel, o_pwm_after_d_sel, o_comparator_input_sel;
  logic [3:0]  i_addr;
  logic [5:0]  o_motor_channel_out, o_motor_channel_oe, o_channel_parity, gate;
  logic [7:0]  i_wdata, i_prev_zc_capture, i_curr_zc_capture, o_rdata, o_next_commutation_compare;
  logic [7:0]  o_commutation_delay;
  logic [10:0] o_off_time_cycles;
  logic [11:0] o_threshold_mv;
  logic [15:0] mv [4] = '{16'h00C8, 16'h0258, 16'h04B0, 16'h09C4};
  logic [15:0] ot [4] = '{16'h00FA, 16'h01F4, 16'h02EE, 16'h05DC};
  row_type     rows [9] = '{'{4'h0, 8'h09, 8'h09}, '{4'h4, 8'hC0, 8'hC0}, '{4'h5, 8'h5A, 8'h5A},
    '{4'h6, 8'h40, 8'h40}, '{4'h1, 8'hC3, 8'hC3}, '{4'h3, 8'hFF, 8'hC0}, '{4'h2, 8'hFF, 8'h00},
    '{4'h7, 8'hFF, 8'h3F}, '{4'hA, 8'h55, 8'h00}};
  int          n_errors = 0;
  int          samples_checked = 0;
  bldc_output_config uut (.i_sys_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_commutation_evt,
    .i_zc_evt, .i_prev_zc_capture, .i_curr_zc_capture, .i_current_cmp, .i_phase_input_a, .i_phase_input_b,
    .i_phase_input_c, .o_motor_channel_out, .o_motor_channel_oe, .o_step_timer_clk_en, .o_periph_clk_en,
    .o_regs_reset_req, .o_sensor_mode, .o_current_mode, .o_auto_commutation, .o_current_cmp_filtered,
    .o_next_commutation_compare, .o_commutation_delay, .o_threshold_sel, .o_threshold_mv, .o_zc_edge_sel,
    .o_hw_demag_en, .o_sw_demag_en, .o_pwm_before_d_sel, .o_pwm_after_d_sel, .o_comparator_input_sel,
    .o_comparator_phase, .o_zc_demag_same_edge, .o_bemf_read_parity, .o_channel_parity, .o_off_time_cycles);
  bridge_switch_model bridge (.i_pin(o_motor_channel_out), .i_oe(o_motor_channel_oe), .o_gate(gate));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    tick(1);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    tick(1);
    i_rd <= 1'b0;
    chk(16'(o_rdata), 16'(exp));
  endtask
  task automatic pulse();
    @(posedge i_sys_clk);
    i_commutation_evt <= 1'b1;
    tick(1);
    i_commutation_evt <= 1'b0;
  endtask
  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Clock
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Watchdog
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    {i_arst_n, i_wr, i_rd, i_commutation_evt, i_zc_evt, i_current_cmp} = 6'h00;
    {i_phase_input_a, i_phase_input_b, i_phase_input_c, i_addr} = 7'h00;
    {i_wdata, i_prev_zc_capture, i_curr_zc_capture} = 24'h001020;
    repeat (16) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    tick(2);
    for (int a = 0; a < 8; a++) rd(a[3:0], (a == 7) ? 8'h3F : 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].r);
    end
    chk(16'(o_commutation_delay), 16'h0040);
    chk(16'({o_current_mode, o_pwm_after_d_sel, o_zc_demag_same_edge, o_bemf_read_parity}), 16'h001F);
    for (int k = 0; k < 4; k++) begin
      wr(4'h1, 8'(k << 6));
      wr(4'h4, 8'(k << 6));
      chk(16'(o_threshold_mv), mv[k]);
      chk(16'(o_threshold_sel), 16'(k));
      chk(16'(o_off_time_cycles), ot[k]);
    end
    // Shadow writes wait for the commutation
    wr(4'h1, 8'h3C);
    wr(4'h3, 8'h2A);
    wr(4'h2, 8'h95);
    rd(4'h1, 8'h00);
    pulse();
    chk(16'({o_zc_edge_sel, o_hw_demag_en, o_sw_demag_en, o_pwm_before_d_sel}), 16'h000F);
    chk(16'({o_comparator_input_sel, o_channel_parity}), 16'h00AA);
    i_phase_input_c <= 1'b1;
    tick(2);
    chk(16'({o_comparator_phase, o_motor_channel_out}), 16'h006A);
    wr(4'h4, 8'h3F);
    tick(1);
    chk(16'(o_motor_channel_out), 16'h0015);
    // Direct access: commutation ignored, phase write commits all
    wr(4'h0, 8'h90);
    chk(16'({o_step_timer_clk_en, o_periph_clk_en}), 16'h0001);
    wr(4'h1, 8'h04);
    wr(4'h3, 8'h01);
    pulse();
    chk(16'(o_channel_parity), 16'h002A);
    wr(4'h2, 8'h07);
    chk(16'({o_zc_edge_sel, o_hw_demag_en, o_sw_demag_en, o_pwm_before_d_sel, o_channel_parity}), 16'h0041);
    tick(1);
    chk(16'(gate), 16'h0007);
    wr(4'h0, 8'h00);
    tick(1);
    chk(16'({o_step_timer_clk_en, gate}), 16'h0000);
    wr(4'h0, 8'h04);
    wr(4'h5, 8'h11);
    rd(4'h5, 8'h5A);
    chk(16'({o_auto_commutation, o_next_commutation_compare}), 16'h015A);
    // Zero crossing loads weight times previous capture over 32
    @(posedge i_sys_clk);
    i_zc_evt <= 1'b1;
    tick(1);
    i_zc_evt <= 1'b0;
    chk(16'(o_next_commutation_compare), 16'h0020);
    wr(4'h0, 8'h22);
    tick(1);
    chk(16'({o_pwm_before_d_sel, o_commutation_delay}), 16'h0020);
    @(posedge i_sys_clk);
    i_current_cmp <= 1'b1;
    @(posedge i_sys_clk);
    i_current_cmp <= 1'b0;
    tick(3);
    chk(16'(o_current_cmp_filtered), 16'h0000);
    i_current_cmp <= 1'b1;
    tick(4);
    chk(16'(o_current_cmp_filtered), 16'h0001);
    wr(4'h0, 8'h00);
    @(posedge i_sys_clk);
    i_current_cmp <= 1'b0;
    tick(1);
    chk(16'(o_current_cmp_filtered), 16'h0000);
    // Mid-run reset returns the registers and enables to zero, then the pins come back at 3F
    wr(4'h0, 8'h40);
    chk(16'({o_regs_reset_req, o_periph_clk_en}), 16'h0002);
    i_arst_n <= 1'b0;
    tick(2);
    chk(16'({o_regs_reset_req, o_motor_channel_oe, o_next_commutation_compare}), 16'h0000);
    i_arst_n <= 1'b1;
    tick(2);
    chk(16'(o_motor_channel_out), 16'h003F);
    rd(4'h2, 8'h00);
    complete_run();
  end
endmodule
